//--- logic/radio_cfg_pkg.sv
/*
  Constants, field layouts and carrier types for the radio frequency and
  address configuration bank.
  Assumes a byte-wide register port decoded elsewhere in the transceiver.
*/
package radio_cfg_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_NODE_ADDRESS    = 6'h09;
  localparam logic [5:0] OFS_CHANNEL_INDEX   = 6'h0a;
  localparam logic [5:0] OFS_SYNTH_IF_CTRL   = 6'h0b;
  localparam logic [5:0] OFS_SYNTH_OFS_CTRL  = 6'h0c;
  localparam logic [5:0] OFS_CARRIER_HIGH    = 6'h0d;
  localparam logic [5:0] OFS_CARRIER_MIDDLE  = 6'h0e;
  localparam logic [5:0] OFS_CARRIER_LOW     = 6'h0f;
  localparam logic [5:0] OFS_BW_RATE_EXP     = 6'h10;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_NODE_ADDRESS    = 8'h00;
  localparam logic [7:0] RST_CHANNEL_INDEX   = 8'h00;
  localparam logic [7:0] RST_SYNTH_IF_CTRL   = 8'h0f;
  localparam logic [7:0] RST_SYNTH_OFS_CTRL  = 8'h00;
  localparam logic [7:0] RST_CARRIER_HIGH    = 8'h1e;
  localparam logic [7:0] RST_CARRIER_MIDDLE  = 8'hc4;
  localparam logic [7:0] RST_CARRIER_LOW     = 8'hec;
  localparam logic [7:0] RST_BW_RATE_EXP     = 8'h8c;

  // ----------------------------------------------------------------
  // Writable masks (fixed-zero bits cleared)
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_FULL           = 8'hff;
  localparam logic [7:0] MASK_SYNTH_IF_CTRL  = 8'h3f;
  localparam logic [7:0] MASK_CARRIER_HIGH   = 8'h3f;

  // ----------------------------------------------------------------
  // Field positions and broadcast codes
  // ----------------------------------------------------------------
  localparam int IF_LSB   = 0;
  localparam int IF_W     = 5;
  localparam int BWE_LSB  = 6;
  localparam int BWM_LSB  = 4;
  localparam int SRE_LSB  = 0;
  localparam logic [7:0] BCAST_ZERO = 8'h00;
  localparam logic [7:0] BCAST_ONES = 8'hff;

  typedef enum logic [1:0] {
    FILT_NONE      = 2'h0,
    FILT_CHECK     = 2'h1,
    FILT_BCAST0    = 2'h2,
    FILT_BCAST0_FF = 2'h3
  } node_filter_select_t;

  // Register port request
  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [5:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // Settings handed to the synthesizer
  typedef struct packed {
    logic [23:0] carrier_word;
    logic [7:0]  channel_index_value;
    logic [4:0]  intermediate_carrier_word_setting;
    logic [7:0]  synth_offset_trim;
  } synth_cfg_t;

  // Settings handed to the modem
  typedef struct packed {
    logic [1:0] bandwidth_exponent;
    logic [1:0] bandwidth_mantissa;
    logic [3:0] symbol_rate_exponent;
    logic [7:0] symbol_rate_mantissa;
  } modem_cfg_t;

endpackage : radio_cfg_pkg

//--- logic/cfg_byte_reg.sv
/*
  One byte-wide configuration register with a writable-bit mask.
  Assumes write strobe and data already synchronous to clk_sys.
*/
`timescale 1ns/1ps
module cfg_byte_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WR_MASK   = 8'hff
) (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       we,
  input  wire logic [7:0] wdata,
  output logic      [7:0] q
);

  logic [7:0] q_r;
  logic [7:0] q_nxt;

  assign q_nxt = we ? (wdata & WR_MASK) : q_r;
  assign q     = q_r;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) q_r <= RESET_VAL;
    else       q_r <= q_nxt;
  end

endmodule : cfg_byte_reg

//--- logic/node_addr_filter.sv
/*
  Received-packet address filter using node address and filter select.
  Assumes a one-cycle strobe with the packet address byte from the packet engine.
*/
`timescale 1ns/1ps
module node_addr_filter
  import radio_cfg_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  input  wire logic                pkt_addr_valid,
  input  wire logic [7:0]          pkt_addr,
  input  wire logic [7:0]          node_address,
  input  wire node_filter_select_t node_filter_select,
  output logic                     addr_result_valid,
  output logic                     addr_accept
);

  logic own_hit;
  logic zero_hit;
  logic ones_hit;
  logic accept_nxt;
  logic valid_r;
  logic accept_r;

  assign own_hit  = (pkt_addr == node_address);
  assign zero_hit = (pkt_addr == BCAST_ZERO);
  assign ones_hit = (pkt_addr == BCAST_ONES);
  assign accept_nxt =
    (node_filter_select == FILT_NONE)      ? 1'b1 :
    (node_filter_select == FILT_CHECK)     ? own_hit :
    (node_filter_select == FILT_BCAST0)    ? (own_hit | zero_hit) :
                                             (own_hit | zero_hit | ones_hit);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      valid_r  <= 1'b0;
      accept_r <= 1'b0;
    end else begin
      valid_r  <= pkt_addr_valid;
      accept_r <= pkt_addr_valid ? accept_nxt : accept_r;
    end
  end

  assign addr_result_valid = valid_r;
  assign addr_accept       = accept_r;

endmodule : node_addr_filter

//--- logic/radio_carrier_word_address_config.sv
/*
  Frequency, address and bandwidth configuration bank of the transceiver.
  Holds the eight byte registers, derives the synthesizer frequency word,
  IF word, decimation settings and symbol-rate settings, and filters
  received packet addresses.
  Assumes a byte register port from the serial host interface on clk_sys,
  and rx_mode, channel spacing, mantissa and filter select from logic on
  the same clock.
*/
`timescale 1ns/1ps
module radio_carrier_word_address_config
  import radio_cfg_pkg::*;
(
  input  wire logic                       clk_sys,
  input  wire logic                       rstn,
  input  wire radio_cfg_pkg::reg_req_t    reg_req,
  output logic                      [7:0] reg_rdata,
  output logic                            reg_rvalid,
  input  wire logic                       rx_mode,
  input  wire logic                 [7:0] channel_spacing,
  input  wire logic                 [7:0] symbol_rate_mantissa,
  input  wire radio_cfg_pkg::node_filter_select_t node_filter_select,
  input  wire logic                       pkt_addr_valid,
  input  wire logic                 [7:0] pkt_addr,
  output logic                            addr_result_valid,
  output logic                            addr_accept,
  output logic                     [31:0] synth_carrier_word_word,
  output logic                     [15:0] mixer_if_word,
  output radio_cfg_pkg::synth_cfg_t       synth_cfg,
  output radio_cfg_pkg::modem_cfg_t       modem_cfg
);
  import radio_cfg_pkg::*;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic sel_node;
  logic sel_channel_index_value;
  logic sel_if;
  logic sel_ofs;
  logic sel_hi;
  logic sel_mid;
  logic sel_lo;
  logic sel_bw;

  assign sel_node = reg_req.wr_en && (reg_req.addr == OFS_NODE_ADDRESS);
  assign sel_channel_index_value = reg_req.wr_en && (reg_req.addr == OFS_CHANNEL_INDEX);
  assign sel_if   = reg_req.wr_en && (reg_req.addr == OFS_SYNTH_IF_CTRL);
  assign sel_ofs  = reg_req.wr_en && (reg_req.addr == OFS_SYNTH_OFS_CTRL);
  assign sel_hi   = reg_req.wr_en && (reg_req.addr == OFS_CARRIER_HIGH);
  assign sel_mid  = reg_req.wr_en && (reg_req.addr == OFS_CARRIER_MIDDLE);
  assign sel_lo   = reg_req.wr_en && (reg_req.addr == OFS_CARRIER_LOW);
  assign sel_bw   = reg_req.wr_en && (reg_req.addr == OFS_BW_RATE_EXP);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] node_address;
  logic [7:0] channel_index;
  logic [7:0] synth_if_control;
  logic [7:0] synth_offset_control;
  logic [7:0] carrier_word_high;
  logic [7:0] carrier_word_middle;
  logic [7:0] carrier_word_low;
  logic [7:0] bandwidth_and_rate_exp;

  cfg_byte_reg #(.RESET_VAL(RST_NODE_ADDRESS), .WR_MASK(MASK_FULL)) u_node (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .we      (sel_node),
    .wdata   (reg_req.wdata),
    .q       (node_address)
  );

  cfg_byte_reg #(.RESET_VAL(RST_CHANNEL_INDEX), .WR_MASK(MASK_FULL)) u_channel_index_value (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .we      (sel_channel_index_value),
    .wdata   (reg_req.wdata),
    .q       (channel_index)
  );

  // Bits 7:6 fixed zero, bit 5 reserved but stored
  cfg_byte_reg #(.RESET_VAL(RST_SYNTH_IF_CTRL), .WR_MASK(MASK_SYNTH_IF_CTRL)) u_if (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .we      (sel_if),
    .wdata   (reg_req.wdata),
    .q       (synth_if_control)
  );

  cfg_byte_reg #(.RESET_VAL(RST_SYNTH_OFS_CTRL), .WR_MASK(MASK_FULL)) u_ofs (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .we      (sel_ofs),
    .wdata   (reg_req.wdata),
    .q       (synth_offset_control)
  );

  cfg_byte_reg #(.RESET_VAL(RST_CARRIER_HIGH), .WR_MASK(MASK_CARRIER_HIGH)) u_hi (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .we      (sel_hi),
    .wdata   (reg_req.wdata),
    .q       (carrier_word_high)
  );

  cfg_byte_reg #(.RESET_VAL(RST_CARRIER_MIDDLE), .WR_MASK(MASK_FULL)) u_mid (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .we      (sel_mid),
    .wdata   (reg_req.wdata),
    .q       (carrier_word_middle)
  );

  cfg_byte_reg #(.RESET_VAL(RST_CARRIER_LOW), .WR_MASK(MASK_FULL)) u_lo (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .we      (sel_lo),
    .wdata   (reg_req.wdata),
    .q       (carrier_word_low)
  );

  cfg_byte_reg #(.RESET_VAL(RST_BW_RATE_EXP), .WR_MASK(MASK_FULL)) u_bw (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .we      (sel_bw),
    .wdata   (reg_req.wdata),
    .q       (bandwidth_and_rate_exp)
  );

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;
  logic [7:0] rdata_r;
  logic       rvalid_r;

  assign rd_mux =
    (reg_req.addr == OFS_NODE_ADDRESS)   ? node_address :
    (reg_req.addr == OFS_CHANNEL_INDEX)  ? channel_index :
    (reg_req.addr == OFS_SYNTH_IF_CTRL)  ? synth_if_control :
    (reg_req.addr == OFS_SYNTH_OFS_CTRL) ? synth_offset_control :
    (reg_req.addr == OFS_CARRIER_HIGH)   ? carrier_word_high :
    (reg_req.addr == OFS_CARRIER_MIDDLE) ? carrier_word_middle :
    (reg_req.addr == OFS_CARRIER_LOW)    ? carrier_word_low :
    (reg_req.addr == OFS_BW_RATE_EXP)    ? bandwidth_and_rate_exp :
                                           8'h00;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= reg_req.rd_en ? rd_mux : rdata_r;
      rvalid_r <= reg_req.rd_en;
    end
  end

  assign reg_rdata  = rdata_r;
  assign reg_rvalid = rvalid_r;

  // ----------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------
  logic [23:0] carrier_word;
  logic [4:0]  intermediate_carrier_word_setting;
  logic [7:0]  synth_offset_trim;
  logic [1:0]  bandwidth_exponent;
  logic [1:0]  bandwidth_mantissa;
  logic [3:0]  symbol_rate_exponent;

  assign carrier_word = {carrier_word_high, carrier_word_middle, carrier_word_low};
  assign intermediate_carrier_word_setting = synth_if_control[IF_LSB +: IF_W];
  assign synth_offset_trim  = synth_offset_control;
  assign bandwidth_exponent = bandwidth_and_rate_exp[BWE_LSB +: 2];
  assign bandwidth_mantissa = bandwidth_and_rate_exp[BWM_LSB +: 2];
  assign symbol_rate_exponent = bandwidth_and_rate_exp[SRE_LSB +: 4];

  // ----------------------------------------------------------------
  // Synthesizer word, units of f_xosc / 2^24
  // ----------------------------------------------------------------
  // Channel term: spacing already in base units
  logic [15:0] channel_index_value_product;
  logic [31:0] base_ext;
  logic [31:0] channel_index_value_ext;
  logic [31:0] ofs_ext;
  logic [31:0] if_ext;
  logic [31:0] carrier_word_nxt;
  logic [31:0] carrier_word_r;

  assign channel_index_value_product = channel_index * channel_spacing;
  assign base_ext = {carrier_word, 8'h00};
  assign channel_index_value_ext = {8'h00, channel_index_value_product, 8'h00};
  // Offset step 2^10 coarser: sign-extend, scale by 2^-14 relative to 2^-24 grid
  assign ofs_ext  = {{14{synth_offset_trim[7]}}, synth_offset_trim, 10'h000};
  // IF step 2^14 coarser: 2^-10 of f_xosc on 2^-24 grid is shift by 14
  assign if_ext   = {13'h0000, intermediate_carrier_word_setting, 14'h0000};
  assign carrier_word_nxt = base_ext + channel_index_value_ext + ofs_ext - (rx_mode ? if_ext : 32'h0000_0000);

  logic [15:0] mixer_r;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      carrier_word_r  <= 32'h0000_0000;
      mixer_r <= 16'h0000;
    end else begin
      carrier_word_r  <= carrier_word_nxt;
      mixer_r <= {intermediate_carrier_word_setting, 11'h000};
    end
  end

  assign synth_carrier_word_word = carrier_word_r;
  assign mixer_if_word   = mixer_r;

  // ----------------------------------------------------------------
  // Settings outputs
  // ----------------------------------------------------------------
  synth_cfg_t synth_cfg_r;
  modem_cfg_t modem_cfg_r;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      synth_cfg_r <= '0;
      modem_cfg_r <= '0;
    end else begin
      synth_cfg_r <= '{carrier_word, channel_index, intermediate_carrier_word_setting,
                       synth_offset_trim};
      modem_cfg_r <= '{bandwidth_exponent, bandwidth_mantissa,
                       symbol_rate_exponent, symbol_rate_mantissa};
    end
  end

  assign synth_cfg = synth_cfg_r;
  assign modem_cfg = modem_cfg_r;

  // ----------------------------------------------------------------
  // Packet address filter
  // ----------------------------------------------------------------
  node_addr_filter u_filter (
    .clk_sys            (clk_sys),
    .rstn               (rstn),
    .pkt_addr_valid     (pkt_addr_valid),
    .pkt_addr           (pkt_addr),
    .node_address       (node_address),
    .node_filter_select (node_filter_select),
    .addr_result_valid  (addr_result_valid),
    .addr_accept        (addr_accept)
  );

endmodule : radio_carrier_word_address_config

//--- testbench/reg_host_model.sv
/*
  Host side of the byte register port: write and read tasks.
  Assumes the bank samples requests on the rising edge of clk_sys.
*/
`timescale 1ns/1ps
module reg_host_model
  import radio_cfg_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic [7:0]           reg_rdata,
  input  wire logic                 reg_rvalid,
  output radio_cfg_pkg::reg_req_t   reg_req
);
  initial reg_req = '0;

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = (a == OFS_SYNTH_IF_CTRL) ? (d & 8'hdf) : d;
    @(posedge clk_sys);
    reg_req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: v};
    @(posedge clk_sys);
    reg_req <= '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: ~v};
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic ok);
    @(posedge clk_sys);
    reg_req <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    reg_req <= '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: 8'h5a};
    @(posedge clk_sys);
    ok = reg_rvalid;
    d = reg_rdata;
  endtask : rd
endmodule : reg_host_model

//--- testbench/rfac_assertions.sv
/*
  Port-level checks of the configuration bank.
  Assumes one clock domain and the bind at the foot of this file.
*/
`timescale 1ns/1ps
module rfac_assertions
  import radio_cfg_pkg::*;
(
  input wire logic                 clk_sys,
  input wire logic                 rstn,
  input wire reg_req_t             reg_req,
  input wire logic [7:0]           reg_rdata,
  input wire logic                 reg_rvalid,
  input wire logic                 rx_mode,
  input wire logic [7:0]           channel_spacing,
  input wire logic [7:0]           symbol_rate_mantissa,
  input wire node_filter_select_t  node_filter_select,
  input wire logic                 pkt_addr_valid,
  input wire logic [7:0]           pkt_addr,
  input wire logic                 addr_result_valid,
  input wire logic                 addr_accept,
  input wire logic [31:0]          synth_carrier_word_word,
  input wire logic [15:0]          mixer_if_word,
  input wire synth_cfg_t           synth_cfg,
  input wire modem_cfg_t           modem_cfg
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  property p_rd_answer; reg_req.rd_en |=> reg_rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer missing");
  property p_rd_pulse; !reg_req.rd_en |=> !reg_rvalid && $stable(reg_rdata); endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read data moved unasked");
  property p_filt_answer; $past(rstn) |-> addr_result_valid == $past(pkt_addr_valid); endproperty
  a_filt_answer: assert property (p_filt_answer) else $error("filter answer timing");
  property p_accept_hold; !addr_result_valid |-> $stable(addr_accept); endproperty
  a_accept_hold: assert property (p_accept_hold) else $error("accept moved unasked");
  property p_open; pkt_addr_valid && node_filter_select == FILT_NONE |=> addr_accept; endproperty
  a_open: assert property (p_open) else $error("open filter rejected");
  property p_bcast0;
    pkt_addr_valid && node_filter_select[1] && pkt_addr == BCAST_ZERO |=> addr_accept;
  endproperty
  a_bcast0: assert property (p_bcast0) else $error("zero broadcast rejected");
  property p_bcast_ff;
    pkt_addr_valid && node_filter_select == FILT_BCAST0_FF && pkt_addr == BCAST_ONES
      |=> addr_accept;
  endproperty
  a_bcast_ff: assert property (p_bcast_ff) else $error("ones broadcast rejected");
  property p_high_zero; synth_cfg.carrier_word[23:22] == 2'h0; endproperty
  a_high_zero: assert property (p_high_zero) else $error("carrier top bits set");
  property p_mixer; mixer_if_word == {synth_cfg.intermediate_carrier_word_setting, 11'h000}; endproperty
  a_mixer: assert property (p_mixer) else $error("mixer word mismatch");
  property p_carrier_word;
    $past(rstn) |-> synth_carrier_word_word == 32'({synth_cfg.carrier_word, 8'h00}
      + {8'h00, (16'(synth_cfg.channel_index_value) * 16'($past(channel_spacing))), 8'h00}
      + {{14{synth_cfg.synth_offset_trim[7]}}, synth_cfg.synth_offset_trim, 10'h000}
      - ($past(rx_mode) ? {13'h0000, synth_cfg.intermediate_carrier_word_setting, 14'h0000} : 32'h0));
  endproperty
  a_carrier_word: assert property (p_carrier_word) else $error("frequency word mismatch");
  property p_rate;
    $past(rstn) |-> modem_cfg.symbol_rate_mantissa == $past(symbol_rate_mantissa);
  endproperty
  a_rate: assert property (p_rate) else $error("rate mantissa mismatch");
endmodule : rfac_assertions

bind radio_carrier_word_address_config rfac_assertions u_chk (
  .clk_sys(clk_sys), .rstn(rstn), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .rx_mode(rx_mode), .channel_spacing(channel_spacing),
  .symbol_rate_mantissa(symbol_rate_mantissa), .node_filter_select(node_filter_select),
  .pkt_addr_valid(pkt_addr_valid), .pkt_addr(pkt_addr),
  .addr_result_valid(addr_result_valid), .addr_accept(addr_accept),
  .synth_carrier_word_word(synth_carrier_word_word), .mixer_if_word(mixer_if_word),
  .synth_cfg(synth_cfg), .modem_cfg(modem_cfg)
);

//--- testbench/tb.sv
/*
  Self-checking bench for the frequency and address configuration bank.
  Assumes the host model and the bound checker are compiled first.
*/
`timescale 1ns/1ps
module tb;
  import radio_cfg_pkg::*;
  logic                clk_sys, rstn, rx_mode, pkt_addr_valid, ok;
  logic [7:0]          channel_spacing, symbol_rate_mantissa, pkt_addr, d, reg_rdata;
  logic                reg_rvalid, addr_result_valid, addr_accept;
  logic [31:0]         synth_carrier_word_word;
  logic [15:0]         mixer_if_word;
  node_filter_select_t node_filter_select;
  reg_req_t            reg_req;
  synth_cfg_t          synth_cfg;
  modem_cfg_t          modem_cfg;
  int                  failures, check_count, cycles;
  localparam logic [7:0] RST_TBL [8] = '{8'h00, 8'h00, 8'h0f, 8'h00, 8'h1e, 8'hc4, 8'hec, 8'h8c};
  localparam logic [7:0] ADR_TBL [4] = '{8'h5a, 8'h00, 8'hff, 8'h33};

  // ----------------------------------------------------------------
  // Clock, instances, helpers
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  reg_host_model host (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
                       .reg_req(reg_req));
  radio_carrier_word_address_config dut (.clk_sys(clk_sys), .rstn(rstn), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .rx_mode(rx_mode),
    .channel_spacing(channel_spacing), .symbol_rate_mantissa(symbol_rate_mantissa),
    .node_filter_select(node_filter_select), .pkt_addr_valid(pkt_addr_valid),
    .pkt_addr(pkt_addr), .addr_result_valid(addr_result_valid), .addr_accept(addr_accept),
    .synth_carrier_word_word(synth_carrier_word_word), .mixer_if_word(mixer_if_word),
    .synth_cfg(synth_cfg), .modem_cfg(modem_cfg));

  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic end_of_test();
    if (failures == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test

  function automatic logic [7:0] msk(input logic [5:0] a);
    if (a == OFS_SYNTH_IF_CTRL) msk = 8'h1f;
    else if (a == OFS_CARRIER_HIGH) msk = 8'h3f;
    else if (a >= OFS_NODE_ADDRESS && a <= OFS_BW_RATE_EXP) msk = 8'hff;
    else msk = 8'h00;
  endfunction : msk

  task automatic filt(input logic [7:0] a, input logic exp);
    @(posedge clk_sys);
    pkt_addr_valid <= 1'b1;
    pkt_addr <= a;
    @(posedge clk_sys);
    pkt_addr_valid <= 1'b0;
    pkt_addr <= ~a;
    @(posedge clk_sys);
    chk("result valid", addr_result_valid, 1);
    chk("address accept", addr_accept, exp);
  endtask : filt

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    rx_mode = 1'b0;
    channel_spacing = 8'h40;
    symbol_rate_mantissa = 8'h22;
    node_filter_select = FILT_NONE;
    pkt_addr_valid = 1'b0;
    pkt_addr = 8'h00;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      host.rd(6'(OFS_NODE_ADDRESS + i), d, ok);
      chk("read valid", ok, 1);
      chk("reset value", d, RST_TBL[i]);
    end
    chk("reset modem", modem_cfg, 16'h8c22);
    chk("reset carrier", synth_cfg.carrier_word, {RST_CARRIER_HIGH, RST_CARRIER_MIDDLE, RST_CARRIER_LOW});
    chk("reset carrier_word", synth_carrier_word_word, {RST_CARRIER_HIGH, RST_CARRIER_MIDDLE, RST_CARRIER_LOW, 8'h00});
    foreach (ADR_TBL[p]) begin
      for (logic [5:0] a = 6'h08; a <= 6'h11; a++) begin
        host.wr(a, ~ADR_TBL[p]);
        host.rd(a, d, ok);
        chk("readback", d, ~ADR_TBL[p] & msk(a));
      end
    end
    host.wr(OFS_CARRIER_HIGH, 8'h10);
    host.wr(OFS_CARRIER_MIDDLE, 8'h20);
    host.wr(OFS_CARRIER_LOW, 8'h30);
    host.wr(OFS_CHANNEL_INDEX, 8'h03);
    host.wr(OFS_SYNTH_OFS_CTRL, 8'hf0);
    host.wr(OFS_SYNTH_IF_CTRL, 8'h0f);
    host.wr(OFS_BW_RATE_EXP, 8'h7a);
    symbol_rate_mantissa <= 8'h99;
    for (int r = 0; r < 2; r++) begin
      rx_mode <= r[0];
      repeat (3) @(posedge clk_sys);
      // Base 0x10203000, channel +0xc000, offset -0x4000, receive IF -0x3c000
      chk("carrier_word word", synth_carrier_word_word, r[0] ? 32'h101c_f000 : 32'h1020_b000);
      chk("mixer word", mixer_if_word, 16'h7800);
    end
    chk("modem cfg", modem_cfg, 16'h7a99);
    chk("synth carrier", synth_cfg.carrier_word, 32'h0010_2030);
    chk("synth fields", {synth_cfg.channel_index_value, synth_cfg.intermediate_carrier_word_setting,
        synth_cfg.synth_offset_trim}, {8'h03, 5'h0f, 8'hf0});
    host.wr(OFS_NODE_ADDRESS, 8'h5a);
    for (int m = 0; m < 4; m++) begin
      node_filter_select <= node_filter_select_t'(m);
      for (int k = 0; k < 4; k++) begin
        filt(ADR_TBL[k], m == 0 || k == 0 || (k == 1 && m >= 2) || (k == 2 && m == 3));
      end
    end
    end_of_test();
  end
endmodule : tb
